// ===== inc/ota_end_pkg.sv
// Constants and types shared by the upgrade end framer and its buffer
// ****************************************************************
// Notes on behaviour
// - Upgrade end response frame control is 0x19
// - Response echoes the request sequence number
// - Upgrade end response command identifier is 0x07
// - Manufacturer code at offset 3 echoes request
// - Image type at offset 5 echoes request
// - File version at offset 7 echoes request
// - Current time at 11, upgrade time at 15
// - Immediate upgrade: both times equal, below limit
// - Successful end request yields upgrade end response
// - Unsolicited response may change a scheduled wait
// - Failed end request gets default response, status 0x00
// - Default response control: client 0x10, server 0x18
// - Default response echoes prompting sequence number
// - Default response command identifier is 0x0B
// - Byte 3 source command, byte 4 status
// - Received payload starts at frame offset 21
// - Sent payload in type 0x11 at offset 23
// - Unknown command answered with status 0x81
// ****************************************************************
package ota_end_pkg;
   // ****************************************************************
   // Frame level constants
   // ****************************************************************
   localparam logic [7:0] API_START = 8'h7E;
   localparam logic [7:0] API_RX_TYPE = 8'h91;
   localparam logic [7:0] API_TX_TYPE = 8'h11;
   localparam logic [7:0] F_LEN_HI = 8'h01;
   localparam logic [7:0] F_LEN_LO = 8'h02;
   localparam logic [7:0] F_TYPE = 8'h03;
   localparam logic [7:0] F_FRAME_ID = 8'h04;
   localparam logic [7:0] RX_HDR_FIRST = 8'h04;
   localparam logic [7:0] TX_HDR_FIRST = 8'h05;
   localparam int HDR_LEN = 16;
   localparam logic [7:0] HDR_LEN_B = 8'h10;
   localparam logic [3:0] HDR_SRC_EP = 4'hA;
   localparam logic [3:0] HDR_DST_EP = 4'hB;
   localparam logic [7:0] F_RADIUS = 8'h15;
   localparam logic [7:0] F_OPTIONS = 8'h16;
   localparam logic [7:0] RX_PAY_OFS = 8'h15;
   localparam logic [7:0] TX_PAY_OFS = 8'h17;
   localparam logic [7:0] TX_FRAME_ID = 8'h01;
   localparam logic [7:0] TX_RADIUS = 8'h00;
   localparam logic [7:0] TX_OPTIONS = 8'h00;
   localparam logic [7:0] CSUM_BASE = 8'hFF;
   // ****************************************************************
   // Message constants
   // ****************************************************************
   localparam logic [7:0] FC_SRV_CMD = 8'h19;
   localparam logic [7:0] FC_SRV_DFLT = 8'h18;
   localparam logic [7:0] FC_CLI_DFLT = 8'h10;
   localparam logic [7:0] CMD_QUERY_REQ = 8'h01;
   localparam logic [7:0] CMD_BLOCK_REQ = 8'h03;
   localparam logic [7:0] CMD_END_REQ = 8'h06;
   localparam logic [7:0] CMD_END_RSP = 8'h07;
   localparam logic [7:0] CMD_DFLT_RSP = 8'h0B;
   localparam logic [7:0] ST_SUCCESS = 8'h00;
   localparam logic [7:0] ST_UNSUP_CMD = 8'h81;
   localparam logic [31:0] IMM_LIMIT = 32'h0FFF_FFFF;
   localparam logic [31:0] TIME_ZERO = 32'h0000_0000;
   // Payload offsets, common and request layout
   localparam logic [7:0] P_FC = 8'h00;
   localparam logic [7:0] P_SEQ = 8'h01;
   localparam logic [7:0] P_CMD = 8'h02;
   localparam logic [7:0] Q_STATUS = 8'h03;
   localparam logic [7:0] Q_MFR = 8'h04;
   localparam logic [7:0] Q_TYPE = 8'h06;
   localparam logic [7:0] Q_VER = 8'h08;
   // Upgrade end response layout
   localparam logic [7:0] R_MFR = 8'h03;
   localparam logic [7:0] R_TYPE = 8'h05;
   localparam logic [7:0] R_VER = 8'h07;
   localparam logic [7:0] R_CUR = 8'h0B;
   localparam logic [7:0] R_UPG = 8'h0F;
   localparam logic [7:0] R_LEN = 8'h13;
   // Default response layout
   localparam logic [7:0] D_SRC = 8'h03;
   localparam logic [7:0] D_STATUS = 8'h04;
   localparam logic [7:0] D_LEN = 8'h05;
   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0]
   {
      KIND_NONE = 2'b00,
      KIND_END_RSP = 2'b01,
      KIND_DFLT_RSP = 2'b10
   } rsp_kind_t;
   typedef enum logic [0:0]
   {
      TX_IDLE = 1'b0,
      TX_SEND = 1'b1
   } tx_state_t;
endpackage

// ===== hw/byte_fifo.sv
// Synchronous FIFO with valid and ready on both sides
module byte_fifo
   import ota_end_pkg::*;
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Filling side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // Draining side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = AW'(DEPTH) == '0 ? {1'b1, {AW{1'b0}}}
                                                       : (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   wire [AW-1:0] last_ptr = AW'(DEPTH - 1);

   // Honest full and empty from the word count
   assign in_ready_o = count != DEPTH_C;
   assign out_valid_o = count != '0;
   assign out_data_o = mem[rd_ptr];

   // Storage write
   always_ff @(posedge clk_i)
   begin
      if (push)
         mem[wr_ptr] <= in_data_i;
   end

   // Pointers and count
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == last_ptr) ? '0 : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == last_ptr) ? '0 : rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule

// ===== hw/ota_upgrade_end_framer.sv
// Upgrade server framer: parses received frames, builds end replies
module ota_upgrade_end_framer
   import ota_end_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Received API frame bytes
   input wire logic [7:0] rx_data_i,
   input wire logic rx_valid_i,
   input wire logic rx_last_i,
   output logic rx_ready_o,
   // Unsolicited upgrade end response request
   input wire logic send_i,
   input wire logic [7:0] send_seq_i,
   input wire logic [15:0] send_mfr_i,
   input wire logic [15:0] send_type_i,
   input wire logic [31:0] send_ver_i,
   output logic send_ready_o,
   // Scheduling times
   input wire logic [31:0] cur_time_i,
   input wire logic [31:0] upg_time_i,
   input wire logic immediate_i,
   // Outgoing API frame bytes
   output logic [7:0] tx_data_o,
   output logic tx_last_o,
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   // Status
   output logic end_req_o,
   output logic [7:0] end_status_o,
   output logic busy_o
);
   // ****************************************************************
   // Receive side parser
   // ****************************************************************
   logic [7:0] rx_idx;
   logic rx_is_91;
   logic [7:0] rx_hdr [HDR_LEN];
   logic [7:0] tx_hdr [HDR_LEN];
   logic hdr_valid;
   logic [7:0] q_seq;
   logic [7:0] q_cmd;
   logic [7:0] q_status;
   logic [15:0] q_mfr;
   logic [15:0] q_type;
   logic [31:0] q_ver;

   tx_state_t state;
   logic [7:0] tx_idx;
   logic [7:0] csum;
   rsp_kind_t rsp_kind;
   logic [7:0] rsp_seq;
   logic [7:0] rsp_src;
   logic [7:0] rsp_status;
   logic [15:0] rsp_mfr;
   logic [15:0] rsp_type;
   logic [31:0] rsp_ver;
   logic [31:0] rsp_cur;
   logic [31:0] rsp_upg;

   // Byte accepted and its place in the payload
   wire rx_take = rx_valid_i && rx_ready_o;
   wire [7:0] p_idx = rx_idx - RX_PAY_OFS;
   wire in_pay = rx_idx >= RX_PAY_OFS;
   wire in_hdr = (rx_idx >= RX_HDR_FIRST)
                 && (rx_idx < RX_HDR_FIRST + HDR_LEN_B);
   wire [3:0] hdr_idx = 4'(rx_idx - RX_HDR_FIRST);
   wire pay_cmd_seen = rx_idx > RX_PAY_OFS + P_CMD;
   wire rx_done = rx_take && rx_last_i;
   wire commit = rx_done && rx_is_91 && pay_cmd_seen;

   // Bytes of the current request, merged with the final byte
   wire [7:0] cmd_now = (in_pay && p_idx == P_CMD) ? rx_data_i : q_cmd;
   wire [7:0] stat_now = (in_pay && p_idx == Q_STATUS) ? rx_data_i
                                                       : q_status;

   // Reply decision
   wire is_end_req = cmd_now == CMD_END_REQ;
   wire end_ok = is_end_req && stat_now == ST_SUCCESS;
   wire end_fail = is_end_req && !end_ok;
   wire known_cmd = (cmd_now == CMD_QUERY_REQ) || (cmd_now == CMD_BLOCK_REQ)
                    || is_end_req || (cmd_now == CMD_DFLT_RSP);
   wire unknown = !known_cmd;
   wire take_send = send_i && send_ready_o && !commit;
   wire want_tx = (commit && (end_ok || end_fail || unknown)) || take_send;
   wire [31:0] imm_value = (cur_time_i < IMM_LIMIT) ? cur_time_i
                                                    : TIME_ZERO;
   wire [31:0] sel_cur = immediate_i ? imm_value : cur_time_i;
   wire [31:0] sel_upg = immediate_i ? imm_value : upg_time_i;

   // Frame byte counter and frame type check
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rx_idx <= 8'h00;
         rx_is_91 <= 1'b0;
      end
      else if (rx_take)
      begin
         rx_idx <= rx_last_i ? 8'h00
                 : (rx_idx == 8'hFF ? rx_idx : rx_idx + 8'h01);
         if (rx_idx == F_TYPE)
            rx_is_91 <= rx_data_i == API_RX_TYPE;
         if (rx_last_i)
            rx_is_91 <= 1'b0;
      end
   end

   // Address header shadow, copied only for a valid received frame
   always_ff @(posedge clk_i)
   begin
      if (rx_take && in_hdr)
         rx_hdr[hdr_idx] <= rx_data_i;
      if (commit)
         tx_hdr <= rx_hdr;
   end

   // Request fields, multi-byte ones arriving low byte first
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         q_seq <= 8'h00;
         q_cmd <= 8'h00;
         q_status <= 8'h00;
         q_mfr <= 16'h0000;
         q_type <= 16'h0000;
         q_ver <= 32'h0000_0000;
      end
      else if (rx_take && in_pay)
      begin
         if (p_idx == P_SEQ)
            q_seq <= rx_data_i;
         if (p_idx == P_CMD)
            q_cmd <= rx_data_i;
         if (p_idx == Q_STATUS)
            q_status <= rx_data_i;
         if (p_idx == Q_MFR)
            q_mfr[7:0] <= rx_data_i;
         if (p_idx == Q_MFR + 8'h01)
            q_mfr[15:8] <= rx_data_i;
         if (p_idx == Q_TYPE)
            q_type[7:0] <= rx_data_i;
         if (p_idx == Q_TYPE + 8'h01)
            q_type[15:8] <= rx_data_i;
         if (p_idx >= Q_VER && p_idx < Q_VER + 8'h04)
            q_ver[8*(p_idx[1:0]) +: 8] <= rx_data_i;
      end
   end

   // End request report and header validity
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         end_req_o <= 1'b0;
         end_status_o <= 8'h00;
         hdr_valid <= 1'b0;
      end
      else
      begin
         end_req_o <= commit && is_end_req;
         if (commit && is_end_req)
            end_status_o <= stat_now;
         if (commit)
            hdr_valid <= 1'b1;
      end
   end

   // ****************************************************************
   // Reply fields latched at the decision
   // ****************************************************************
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rsp_kind <= KIND_NONE;
         rsp_seq <= 8'h00;
         rsp_src <= 8'h00;
         rsp_status <= 8'h00;
         rsp_mfr <= 16'h0000;
         rsp_type <= 16'h0000;
         rsp_ver <= 32'h0000_0000;
         rsp_cur <= 32'h0000_0000;
         rsp_upg <= 32'h0000_0000;
      end
      else if (want_tx)
      begin
         rsp_cur <= sel_cur;
         rsp_upg <= sel_upg;
         if (take_send)
         begin
            rsp_kind <= KIND_END_RSP;
            rsp_seq <= send_seq_i;
            rsp_mfr <= send_mfr_i;
            rsp_type <= send_type_i;
            rsp_ver <= send_ver_i;
         end
         else
         begin
            rsp_kind <= end_ok ? KIND_END_RSP : KIND_DFLT_RSP;
            rsp_seq <= q_seq;
            rsp_src <= cmd_now;
            rsp_status <= end_ok || end_fail ? ST_SUCCESS
                                             : ST_UNSUP_CMD;
            rsp_mfr <= q_mfr;
            rsp_type <= q_type;
            rsp_ver <= q_ver;
         end
      end
   end

   // ****************************************************************
   // Transmit frame builder
   // ****************************************************************
   logic fifo_ready;
   wire [7:0] pay_len = (rsp_kind == KIND_END_RSP) ? R_LEN : D_LEN;
   wire [7:0] last_idx = TX_PAY_OFS + pay_len;
   wire [7:0] len_lo = pay_len + (TX_PAY_OFS - F_TYPE);
   wire [7:0] q = tx_idx - TX_PAY_OFS;
   wire [3:0] th = 4'(tx_idx - TX_HDR_FIRST);
   wire is_hdr = (tx_idx >= TX_HDR_FIRST)
                 && (tx_idx < TX_HDR_FIRST + HDR_LEN_B);
   wire [3:0] th_swap = (th == HDR_SRC_EP) ? HDR_DST_EP
                      : (th == HDR_DST_EP) ? HDR_SRC_EP : th;
   wire [1:0] q_lo = 2'(q - R_VER);
   wire [1:0] c_lo = 2'(q - R_CUR);
   wire [1:0] u_lo = 2'(q - R_UPG);

   // Upgrade end response payload, fields low byte first
   wire [7:0] end_byte =
        (q == P_FC) ? FC_SRV_CMD
      : (q == P_SEQ) ? rsp_seq
      : (q == P_CMD) ? CMD_END_RSP
      : (q == R_MFR) ? rsp_mfr[7:0]
      : (q == R_MFR + 8'h01) ? rsp_mfr[15:8]
      : (q == R_TYPE) ? rsp_type[7:0]
      : (q == R_TYPE + 8'h01) ? rsp_type[15:8]
      : (q < R_CUR) ? rsp_ver[8*q_lo +: 8]
      : (q < R_UPG) ? rsp_cur[8*c_lo +: 8]
      : rsp_upg[8*u_lo +: 8];

   // Default response payload
   wire [7:0] dflt_byte =
        (q == P_FC) ? FC_SRV_DFLT
      : (q == P_SEQ) ? rsp_seq
      : (q == P_CMD) ? CMD_DFLT_RSP
      : (q == D_SRC) ? rsp_src
      : rsp_status;

   // Whole frame byte by position
   wire [7:0] frame_byte =
        (tx_idx == 8'h00) ? API_START
      : (tx_idx == F_LEN_HI) ? 8'h00
      : (tx_idx == F_LEN_LO) ? len_lo
      : (tx_idx == F_TYPE) ? API_TX_TYPE
      : (tx_idx == F_FRAME_ID) ? TX_FRAME_ID
      : is_hdr ? tx_hdr[th_swap]
      : (tx_idx == F_RADIUS) ? TX_RADIUS
      : (tx_idx == F_OPTIONS) ? TX_OPTIONS
      : (tx_idx == last_idx) ? CSUM_BASE - csum
      : (rsp_kind == KIND_END_RSP) ? end_byte : dflt_byte;

   wire tx_push = (state == TX_SEND) && fifo_ready;
   wire tx_end = tx_push && (tx_idx == last_idx);

   // Handshakes: input stalls while a reply is being built, not while it waits in the buffer
   assign rx_ready_o = state == TX_IDLE;
   assign send_ready_o = (state == TX_IDLE) && hdr_valid;
   assign busy_o = state == TX_SEND;

   // Builder state, byte index and running checksum
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state <= TX_IDLE;
         tx_idx <= 8'h00;
         csum <= 8'h00;
      end
      else
      begin
         case (state)
            TX_IDLE:
            begin
               tx_idx <= 8'h00;
               csum <= 8'h00;
               if (want_tx)
                  state <= TX_SEND;
            end
            TX_SEND:
            begin
               if (tx_push)
               begin
                  tx_idx <= tx_idx + 8'h01;
                  if (tx_idx >= F_TYPE)
                     csum <= csum + frame_byte;
               end
               if (tx_end)
                  state <= TX_IDLE;
            end
            default:
               state <= TX_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Output buffer
   // ****************************************************************
   byte_fifo #(
      .WIDTH(9),
      .DEPTH(FIFO_DEPTH)
   ) u_out_fifo (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_data_i({tx_end, frame_byte}),
      .in_valid_i(tx_push),
      .in_ready_o(fifo_ready),
      .out_data_o({tx_last_o, tx_data_o}),
      .out_valid_o(tx_valid_o),
      .out_ready_i(tx_ready_i)
   );
endmodule

// ===== dv/ota_upgrade_end_framer_chk.sv
// Concurrent checks on the ports of the upgrade end framer
module ota_upgrade_end_framer_chk
   import ota_end_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Receive and send requests
   input wire logic rx_valid_i,
   input wire logic rx_ready_o,
   input wire logic send_i,
   input wire logic send_ready_o,
   // Outgoing stream and status
   input wire logic [7:0] tx_data_o,
   input wire logic tx_last_o,
   input wire logic tx_valid_o,
   input wire logic tx_ready_i,
   input wire logic end_req_o,
   input wire logic busy_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************************************
   // Helper logic
   // ****************************************************************
   logic [7:0] tx_cnt;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   // Bytes handed over since the last checksum byte
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         tx_cnt <= 8'h00;
      else if (tx_valid_o && tx_ready_i)
         tx_cnt <= tx_last_o ? 8'h00 : tx_cnt + 8'h01;
   end
   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_reset_idle: assert property ($fell(reset_i) |-> rx_ready_o && !busy_o
      && !tx_valid_o && !send_ready_o && !end_req_o)
      else $error("state after reset is not idle");
   a_frame_len: assert property (tx_valid_o && tx_ready_i
      && tx_last_o |-> tx_cnt == 8'h2A || tx_cnt == 8'h1C)
      else $error("outgoing frame has a wrong byte count");
   a_first_byte: assert property ($rose(busy_o) && !tx_valid_o
      |=> tx_valid_o && tx_data_o == API_START)
      else $error("reply does not open with the start byte");
   a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o
      && $stable(tx_data_o) && $stable(tx_last_o))
      else $error("outgoing byte changed before it was taken");
   a_busy_blocks: assert property (busy_o |-> !rx_ready_o)
      else $error("receive ready while a reply is built");
   a_end_walk: assert property (end_req_o |-> busy_o && !rx_ready_o)
      else $error("end request pulse without a reply in progress");
   a_end_pulse: assert property (end_req_o |=> !end_req_o)
      else $error("end request pulse longer than one cycle");
   a_send_go: assert property (send_i && send_ready_o
      && !rx_valid_i |=> busy_o)
      else $error("accepted send request did not start a reply");
   a_no_cause: assert property (!busy_o && !rx_valid_i
      && !(send_i && send_ready_o) |=> !busy_o)
      else $error("reply started without a cause");
   // Main scenarios
   c_end_req: cover property (end_req_o);
   c_stall_full: cover property (tx_valid_o && !tx_ready_i && busy_o);
   c_send: cover property (send_i && send_ready_o);
   c_frame_done: cover property (tx_valid_o && tx_ready_i && tx_last_o);
endmodule

bind ota_upgrade_end_framer ota_upgrade_end_framer_chk #(
   .FIFO_DEPTH(FIFO_DEPTH)
) i_chk (.clk_i(clk_i), .reset_i(reset_i), .rx_valid_i(rx_valid_i),
   .rx_ready_o(rx_ready_o), .send_i(send_i), .send_ready_o(send_ready_o),
   .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_valid_o(tx_valid_o),
   .tx_ready_i(tx_ready_i), .end_req_o(end_req_o), .busy_o(busy_o));

// ===== dv/ota_client_model.sv
// Client node model: sends framed requests and sinks server replies
module ota_client_model
   import ota_end_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Frames toward the server
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   output logic rx_last_o,
   input wire logic rx_ready_i,
   // Frames from the server
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   input wire logic tx_last_i,
   output logic tx_ready_o,
   // Sink stall request
   input wire logic stall_i
);
   timeunit 1ns;
   timeprecision 100ps;
   // Address header, endpoints differ so a swap shows
   logic [7:0] hdr [0:16] = '{8'h00, 8'h13, 8'hA2, 8'h00, 8'h55, 8'h66,
      8'h77, 8'h88, 8'hFF, 8'hFE, 8'hE6, 8'hE8, 8'h00, 8'h19, 8'hC1, 8'h05,
      8'h01};
   logic [7:0] cap [$];
   int frames = 0;
   initial
   begin
      rx_data_o = 8'h00;
      rx_valid_o = 1'b0;
      rx_last_o = 1'b0;
   end
   assign tx_ready_o = !stall_i;
   // Capture every byte the server hands over
   always @(posedge clk_i)
   begin
      if (tx_valid_i && tx_ready_o)
      begin
         cap.push_back(tx_data_i);
         if (tx_last_i)
            frames++;
      end
   end
   // One request frame, payload from byte 21, fields low byte first
   task automatic send_frame(input logic [7:0] ftype, fc, seq, cmd, st,
      input logic [15:0] mfr, typ, input logic [31:0] ver);
      logic [7:0] b [$];
      logic [7:0] sum;
      b = {8'h7E, 8'h00, 8'h1E, ftype};
      foreach (hdr[i])
         b.push_back(hdr[i]);
      b = {b, fc, seq, cmd, st, mfr[7:0], mfr[15:8], typ[7:0], typ[15:8],
         ver[7:0], ver[15:8], ver[23:16], ver[31:24]};
      sum = 8'h00;
      for (int i = 3; i < b.size(); i++)
         sum += b[i];
      b.push_back(8'hFF - sum);
      @(posedge clk_i);
      #1;
      foreach (b[i])
      begin
         rx_data_o = b[i];
         rx_valid_o = 1'b1;
         rx_last_o = (i == b.size() - 1);
         do @(negedge clk_i); while (rx_ready_i !== 1'b1);
         @(posedge clk_i);
         #1;
      end
      rx_valid_o = 1'b0;
      rx_last_o = 1'b0;
      rx_data_o = ~rx_data_o;
   endtask
endmodule

// ===== dv/test_ota_upgrade_end_framer.sv
// Self-checking bench for the upgrade end framer
module test_ota_upgrade_end_framer
   import ota_end_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // Arbitrary image fields
   localparam logic [15:0] MFR = 16'hA5C3;
   localparam logic [15:0] TYP = 16'h0102;
   localparam logic [31:0] VER = 32'h0403_0201;
   logic clk_i, reset_i, stall, send_req, immediate, send_ready;
   logic [7:0] rx_data, send_seq, tx_data, end_status;
   logic rx_valid, rx_last, rx_ready, tx_last, tx_valid, tx_ready;
   logic end_req, busy;
   logic [15:0] send_mfr, send_type;
   logic [31:0] send_ver, cur_time, upg_time;
   logic [7:0] pay [$];
   int err_count = 0, num_checks = 0, f0 = 0, n_end = 0, cyc = 0;
   ota_upgrade_end_framer #(.FIFO_DEPTH(16)) i_dut (.clk_i(clk_i),
      .reset_i(reset_i), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
      .rx_last_i(rx_last), .rx_ready_o(rx_ready), .send_i(send_req),
      .send_seq_i(send_seq), .send_mfr_i(send_mfr), .send_type_i(send_type),
      .send_ver_i(send_ver), .send_ready_o(send_ready),
      .cur_time_i(cur_time), .upg_time_i(upg_time), .immediate_i(immediate),
      .tx_data_o(tx_data), .tx_last_o(tx_last), .tx_valid_o(tx_valid),
      .tx_ready_i(tx_ready), .end_req_o(end_req), .end_status_o(end_status),
      .busy_o(busy));
   ota_client_model i_client (.clk_i(clk_i), .rx_data_o(rx_data),
      .rx_valid_o(rx_valid), .rx_last_o(rx_last), .rx_ready_i(rx_ready),
      .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_last_i(tx_last),
      .tx_ready_o(tx_ready), .stall_i(stall));
   // Clock generator
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // Pulse counter and hang guard
   always @(posedge clk_i)
   begin
      cyc++;
      if (end_req === 1'b1)
         n_end++;
      if (cyc == 20000)
      begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Send one request frame with the fixed image fields
   task automatic req(input logic [7:0] ftype, fc, seq, cmd, st);
      f0 = i_client.frames;
      i_client.cap.delete();
      i_client.send_frame(ftype, fc, seq, cmd, st, MFR, TYP, VER);
   endtask
   task automatic mk_end(input logic [7:0] seq, input logic [15:0] m, t,
      input logic [31:0] v, c, u);
      logic [31:0] w [3] = '{v, c, u};
      pay = {8'h19, seq, 8'h07, m[7:0], m[15:8], t[7:0], t[15:8]};
      foreach (w[j])
         for (int i = 0; i < 32; i += 8)
            pay.push_back(w[j][i +: 8]);
   endtask
   // Wait for a whole reply and compare it with the expected frame
   task automatic check_reply();
      logic [7:0] e [$];
      logic [7:0] sum;
      int k;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (i_client.frames == f0 && k < 2000);
      #1;
      e = {8'h7E, 8'h00, 8'(pay.size() + 20), 8'h11, 8'h01};
      for (int i = 0; i < 16; i++)
         e.push_back(i_client.hdr[i == 10 ? 11 : i == 11 ? 10 : i]);
      e.push_back(8'h00);
      e.push_back(8'h00);
      foreach (pay[i])
         e.push_back(pay[i]);
      sum = 8'h00;
      for (int i = 3; i < e.size(); i++)
         sum += e[i];
      e.push_back(8'hFF - sum);
      check("frame size", 32'(i_client.cap.size()), 32'(e.size()));
      foreach (e[i])
         check($sformatf("tx byte %0d", i), 32'(i_client.cap[i]),
            32'(e[i]));
   endtask
   // Success with the sink stalled until the buffer is full
   task automatic t_end_ok();
      stall = 1'b1;
      req(API_RX_TYPE, 8'h01, 8'h95, 8'h06, 8'h00);
      repeat (60) @(posedge clk_i);
      #1;
      check("builder held by full buffer", 32'(busy), 32'h1);
      check("buffer offers", 32'(tx_valid), 32'h1);
      stall = 1'b0;
      mk_end(8'h95, MFR, TYP, VER, cur_time, upg_time);
      check_reply();
      check("end pulses", 32'(n_end), 32'h1);
      check("end status", 32'(end_status), 32'h0);
   endtask
   // Immediate upgrade, below and at the limit
   task automatic t_immediate();
      logic [31:0] c [2] = '{32'h0FFF_FFFE, 32'h0FFF_FFFF};
      immediate = 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         cur_time = c[i];
         req(API_RX_TYPE, 8'h01, 8'(8'h20 + i), 8'h06, 8'h00);
         mk_end(8'(8'h20 + i), MFR, TYP, VER, i == 0 ? c[i] : 32'h0,
            i == 0 ? c[i] : 32'h0);
         check_reply();
      end
      immediate = 1'b0;
      cur_time = 32'h1234_5678;
   endtask
   // Error statuses get an acknowledging default response
   task automatic t_end_fail();
      logic [7:0] st [3] = '{8'h96, 8'h95, 8'h99};
      foreach (st[i])
      begin
         req(API_RX_TYPE, 8'h01, 8'(8'h41 + i), 8'h06, st[i]);
         pay = {8'h18, 8'(8'h41 + i), 8'h0B, 8'h06, 8'h00};
         check_reply();
         check("end status", 32'(end_status), 32'(st[i]));
      end
   endtask
   // Unknown command, then frames that must get no reply
   task automatic t_other();
      logic [7:0] cmd [4] = '{8'h01, 8'h03, 8'h0B, 8'h06};
      req(API_RX_TYPE, 8'h01, 8'h66, 8'h42, 8'h00);
      pay = {8'h18, 8'h66, 8'h0B, 8'h42, 8'h81};
      check_reply();
      foreach (cmd[i])
      begin
         req(i == 3 ? 8'h90 : API_RX_TYPE, i == 2 ? 8'h10 : 8'h01, 8'h33,
            cmd[i], 8'h00);
         repeat (80) @(posedge clk_i);
         #1;
         check("no reply", 32'(i_client.frames - f0), 32'h0);
      end
   endtask
   // Unsolicited response built from the send fields
   task automatic t_unsol();
      f0 = i_client.frames;
      i_client.cap.delete();
      send_seq = 8'h5A;
      send_mfr = 16'h7788;
      send_type = 16'h0009;
      send_ver = 32'h0A0B_0C0D;
      send_req = 1'b1;
      do @(negedge clk_i); while (send_ready !== 1'b1);
      @(posedge clk_i);
      #1;
      send_req = 1'b0;
      mk_end(8'h5A, 16'h7788, 16'h0009, 32'h0A0B_0C0D, cur_time, upg_time);
      check_reply();
   endtask
   // Main sequence
   initial
   begin
      reset_i = 1'b1;
      {stall, send_req, immediate, send_seq} = '0;
      {send_mfr, send_type, send_ver} = '0;
      cur_time = 32'h1234_5678;
      upg_time = 32'h2233_4455;
      repeat (3) @(posedge clk_i);
      #1;
      reset_i = 1'b0;
      t_end_ok();
      t_immediate();
      t_end_fail();
      t_other();
      t_unsol();
      report_and_stop();
   end
endmodule
